// *** design/llt_line_stage.sv ***
// Purpose: pixel lookup, per-line trailer record, correction entry selection
// Assumes: camera and pins synchronous to ref_clk; idle gap after each line
// Notes:   trailer words wait while pixels of the next line pass
////////////////////////////////////////////////////////////////////////////////

// Functional notes
// - 8-bit input maps to 8 out only
// - 10-bit input maps to 8 or low-10
// - 12-bit input gives 8 MSB or low-12
// - no table used: pack in low bits
// - 64-byte trailer after every line when enabled
// - trailer fields snapshot at line start
// - 64-bit encoder up/down position count
// - 64-bit count of received lines
// - 64-bit count of sent line triggers
// - trailer carries 64-bit timestamp
// - 32-bit frame number of the line
// - one byte each for pin levels
// - last 25 trailer bytes reserved zero
// - automatic mode steps entries each frame
// - manual mode uses chosen entry, ignores sets
// - set change while running waits for current pass end
// - selecting a set restarts at first entry
// - stopped start pair picks pair modulo length
// - up to 16 sets selectable
// - coefficient writes accepted any time
module llt_line_stage (
    input  wire logic                  ref_clk,
    input  wire logic                  rst_n,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [7:0]            paddr,
    input  wire logic [31:0]           pwdata,
    output logic [31:0]                prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic                  line_valid_strobe,
    input  wire logic                  frame_valid,
    input  wire llt_pkg::llt_pix_in_t  pix_in,
    input  wire logic                  enc_fwd_pulse,
    input  wire logic                  enc_rev_pulse,
    input  wire logic                  line_trigger_sent,
    input  wire logic [7:0]            input_pin_levels,
    input  wire logic [7:0]            output_pin_levels,
    input  wire logic [7:0]            bidir_pin_levels,
    output llt_pkg::llt_pix_out_t      pix_out,
    output logic [7:0]                 correction_entry,
    output logic                       coeff_wr,
    output logic [31:0]                coeff_wdata
);
    import llt_pkg::*;
    typedef enum logic {TR_IDLE, TR_SEND} llt_trail_t;
    logic [6:0]         ctrl_q;
    logic [3:0]         list_len_q;
    logic [3:0]         correction_set_index_q;
    logic [3:0]         pending_set_q;
    logic [7:0]         correction_entry_index_q;
    logic [9:0]         lut_addr_q;
    logic [15:0]        lut_q [LUT_DEPTH];
    logic [3:0]         active_set_q;
    logic [3:0]         pos_q;
    logic [7:0]         entry_q;
    logic               lv_q;
    logic               fv_q;
    logic [63:0]        encoder_position_count_q;
    logic [63:0]        received_line_total_q;
    logic [63:0]        sent_line_trigger_total_q;
    logic [63:0]        stamp_q;
    logic [31:0]        received_frame_number_q;
    llt_record_t        snap_q;
    llt_trail_t         trail_q;
    logic [4:0]         word_q;
    llt_pix_out_t       out_q;
    logic               wr_en;
    logic               rd_en;
    logic               line_start;
    logic               line_end;
    logic               frame_start;
    logic               running;
    logic               auto_mode;
    logic [1:0]         width;
    logic [511:0]       record;
    logic [15:0]        pix_fmt;
    logic [31:0]        rd_mux;

    assign wr_en       = psel && penable && pwrite;
    assign rd_en       = psel && !pwrite;
    assign line_start  = line_valid_strobe && !lv_q;
    assign line_end    = !line_valid_strobe && lv_q;
    assign frame_start = frame_valid && !fv_q;
    assign running     = ctrl_q[CTRL_RUN];
    assign auto_mode   = ctrl_q[CTRL_AUTO];
    assign width       = ctrl_q[CTRL_WIDTH_L +: 2];
    assign pready      = 1'b1;
    assign pix_out     = out_q;
    assign correction_entry = entry_q;

    function automatic logic mapped(input logic [7:0] a);
        unique case (a)
            OFS_CTRL, OFS_LIST_LEN, OFS_SET, OFS_ENTRY, OFS_PAIR,
            OFS_STATUS, OFS_LUT_ADDR, OFS_LUT_DATA, OFS_FRAME: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    endfunction
    ////////////////////////////////////////////////////////////////////////////
    // register file
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q                   <= CTRL_RESET;
            list_len_q               <= 4'h0;
            correction_entry_index_q <= 8'h00;
        end else if (wr_en) begin
            unique case (paddr)
                OFS_CTRL:     ctrl_q <= pwdata[6:0];
                OFS_LIST_LEN: list_len_q <= pwdata[3:0];
                OFS_ENTRY:    correction_entry_index_q <= pwdata[7:0];
                default:      ;
            endcase
        end
    end
    // table writes and coefficient uploads are never blocked by acquisition
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            lut_addr_q  <= 10'h000;
            coeff_wr    <= 1'b0;
            coeff_wdata <= 32'h0000_0000;
        end else begin
            coeff_wr <= 1'b0;
            if (wr_en && paddr == OFS_LUT_ADDR) begin
                lut_addr_q <= pwdata[9:0];
            end else if (wr_en && paddr == OFS_LUT_DATA) begin
                lut_addr_q  <= lut_addr_q + 10'h001;
                coeff_wr    <= 1'b1;
                coeff_wdata <= pwdata;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (wr_en && paddr == OFS_LUT_DATA) begin
            lut_q[lut_addr_q] <= pwdata[15:0];
        end
    end

    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (paddr)
            OFS_CTRL:     rd_mux = {25'h0, ctrl_q};
            OFS_LIST_LEN: rd_mux = {28'h0, list_len_q};
            OFS_SET:      rd_mux = {28'h0, correction_set_index_q};
            OFS_ENTRY:    rd_mux = {24'h0, correction_entry_index_q};
            OFS_STATUS:   rd_mux = {16'h0, entry_q, pos_q, active_set_q};
            OFS_LUT_ADDR: rd_mux = {22'h0, lut_addr_q};
            OFS_LUT_DATA: rd_mux = {16'h0, lut_q[lut_addr_q]};
            OFS_FRAME:    rd_mux = received_frame_number_q;
            default:      rd_mux = 32'h0000_0000;
        endcase
    end

    assign prdata  = rd_en ? rd_mux : 32'h0000_0000;
    assign pslverr = psel && penable && !mapped(paddr);
    ////////////////////////////////////////////////////////////////////////////
    // counters and edge history
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            lv_q <= 1'b0;
            fv_q <= 1'b0;
        end else begin
            lv_q <= line_valid_strobe;
            fv_q <= frame_valid;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            encoder_position_count_q <= 64'h0;
        end else if (enc_fwd_pulse && !enc_rev_pulse) begin
            encoder_position_count_q <= encoder_position_count_q + 64'h1;
        end else if (enc_rev_pulse && !enc_fwd_pulse) begin
            encoder_position_count_q <= encoder_position_count_q - 64'h1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            received_line_total_q     <= 64'h0;
            sent_line_trigger_total_q <= 64'h0;
            stamp_q                   <= 64'h0;
            received_frame_number_q   <= 32'h0;
        end else begin
            stamp_q <= stamp_q + 64'h1;
            if (line_start) begin
                received_line_total_q <= received_line_total_q + 64'h1;
            end
            if (line_trigger_sent) begin
                sent_line_trigger_total_q <=
                    sent_line_trigger_total_q + 64'h1;
            end
            if (frame_start) begin
                received_frame_number_q <=
                    received_frame_number_q + 32'h1;
            end
        end
    end
    // frame number includes a frame start seen in the same cycle as the line start
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            snap_q <= '0;
        end else if (line_start) begin
            snap_q.enc   <= encoder_position_count_q;
            snap_q.lines <= received_line_total_q;
            snap_q.trig  <= sent_line_trigger_total_q;
            snap_q.stamp <= stamp_q;
            snap_q.frame <= frame_start ? received_frame_number_q + 32'h1
                                        : received_frame_number_q;
            snap_q.ins   <= input_pin_levels;
            snap_q.outs  <= output_pin_levels;
            snap_q.bidir <= bidir_pin_levels;
        end
    end
    assign record = {{RESERVED_BYTES{8'h00}}, snap_q};
    ////////////////////////////////////////////////////////////////////////////
    // pixel formatting
    always_comb begin
        pix_fmt = 16'h0000;
        unique case (width)
            WIDTH_12: begin
                if (ctrl_q[CTRL_OUT16]) begin
                    pix_fmt = {4'h0, pix_in.data};
                end else begin
                    pix_fmt = {8'h00, pix_in.data[11:4]};
                end
            end
            WIDTH_10: begin
                if (!ctrl_q[CTRL_LUT_EN]) begin
                    pix_fmt = {6'h00, pix_in.data[9:0]};
                end else if (ctrl_q[CTRL_OUT16]) begin
                    pix_fmt = {6'h00, lut_q[pix_in.data[9:0]][9:0]};
                end else begin
                    pix_fmt = {8'h00, lut_q[pix_in.data[9:0]][7:0]};
                end
            end
            default: begin
                if (!ctrl_q[CTRL_LUT_EN]) begin
                    pix_fmt = {8'h00, pix_in.data[7:0]};
                end else begin
                    pix_fmt = {8'h00,
                               lut_q[{2'h0, pix_in.data[7:0]}][7:0]};
                end
            end
        endcase
    end
    ////////////////////////////////////////////////////////////////////////////
    // output stream with trailer
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            trail_q <= TR_IDLE;
            word_q  <= 5'h00;
            out_q   <= '0;
        end else begin
            out_q <= '0;
            if (pix_in.valid) begin
                out_q.valid <= 1'b1;
                out_q.data  <= pix_fmt;
            end else if (trail_q == TR_SEND) begin
                out_q.valid   <= 1'b1;
                out_q.trailer <= 1'b1;
                out_q.data    <= record[{word_q, 4'h0} +: 16];
                word_q        <= word_q + 5'h01;
            end
            unique case (trail_q)
                TR_IDLE: begin
                    if (line_end && ctrl_q[CTRL_TRAILER]) begin
                        trail_q <= TR_SEND;
                        word_q  <= 5'h00;
                    end
                end
                TR_SEND: begin
                    if (!pix_in.valid && word_q == LAST_WORD) begin
                        trail_q <= TR_IDLE;
                    end
                end
            endcase
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // correction entry selection
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            correction_set_index_q <= 4'h0;
            pending_set_q          <= 4'h0;
            active_set_q           <= 4'h0;
            pos_q                  <= 4'h0;
            entry_q                <= 8'h00;
        end else begin
            if (wr_en && paddr == OFS_SET) begin
                correction_set_index_q <= pwdata[3:0];
                pending_set_q          <= pwdata[3:0];
                if (!running) begin
                    active_set_q <= pwdata[3:0];
                    pos_q        <= 4'h0;
                end
            end
            if (wr_en && paddr == OFS_PAIR && !running) begin
                pos_q <= 4'(pwdata[7:0] % ({4'h0, list_len_q} + 8'h01));
            end else if (frame_start && running) begin
                if (!auto_mode) begin
                    entry_q <= correction_entry_index_q;
                end else begin
                    entry_q <= {active_set_q, pos_q};
                    if (pos_q == list_len_q) begin
                        pos_q        <= 4'h0;
                        active_set_q <= pending_set_q;
                    end else begin
                        pos_q <= pos_q + 4'h1;
                    end
                end
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // checks
    property p_enc_up;
        @(posedge ref_clk) disable iff (!rst_n)
        enc_fwd_pulse && !enc_rev_pulse |=>
            encoder_position_count_q == $past(encoder_position_count_q) + 1;
    endproperty
    a_enc_up: assert property (p_enc_up)
        else $error("encoder count did not step up");
    property p_line_count;
        @(posedge ref_clk) disable iff (!rst_n)
        line_start |=> received_line_total_q == $past(received_line_total_q) + 1;
    endproperty
    a_line_count: assert property (p_line_count)
        else $error("line total did not step");
    property p_snapshot;
        @(posedge ref_clk) disable iff (!rst_n)
        line_start |=> snap_q.enc == $past(encoder_position_count_q)
                       && snap_q.ins == $past(input_pin_levels);
    endproperty
    a_snapshot: assert property (p_snapshot)
        else $error("trailer snapshot not taken at line start");
    property p_trailer_start;
        @(posedge ref_clk) disable iff (!rst_n)
        line_end && ctrl_q[CTRL_TRAILER] && trail_q == TR_IDLE
            ##1 !pix_in.valid |=> out_q.trailer && out_q.data == snap_q.enc[15:0];
    endproperty
    a_trailer_start: assert property (p_trailer_start)
        else $error("trailer did not follow line end");
    property p_trailer_end;
        @(posedge ref_clk) disable iff (!rst_n)
        trail_q == TR_SEND && word_q == LAST_WORD && !pix_in.valid
            |=> out_q.trailer && out_q.data == 16'h0000 ##1 !out_q.trailer;
    endproperty
    a_trailer_end: assert property (p_trailer_end)
        else $error("trailer length or reserved tail wrong");
    property p_pack_10;
        @(posedge ref_clk) disable iff (!rst_n)
        pix_in.valid && width == WIDTH_10 && !ctrl_q[CTRL_LUT_EN]
            |=> out_q.data == {6'h00, $past(pix_in.data[9:0])};
    endproperty
    a_pack_10: assert property (p_pack_10)
        else $error("bypass packing wrong");
    property p_msb_12;
        @(posedge ref_clk) disable iff (!rst_n)
        pix_in.valid && width == WIDTH_12 && !ctrl_q[CTRL_OUT16]
            |=> out_q.data == {8'h00, $past(pix_in.data[11:4])};
    endproperty
    a_msb_12: assert property (p_msb_12)
        else $error("12-bit to 8-bit not the top bits");
    property p_manual;
        @(posedge ref_clk) disable iff (!rst_n)
        frame_start && running && !auto_mode && !wr_en
            |=> entry_q == $past(correction_entry_index_q);
    endproperty
    a_manual: assert property (p_manual)
        else $error("manual entry not applied");
    property p_auto_step;
        @(posedge ref_clk) disable iff (!rst_n)
        frame_start && running && auto_mode && !wr_en && pos_q != list_len_q
            |=> pos_q == $past(pos_q) + 1 && active_set_q == $past(active_set_q);
    endproperty
    a_auto_step: assert property (p_auto_step)
        else $error("round robin step wrong");
    c_trailer: cover property (@(posedge ref_clk) disable iff (!rst_n)
        trail_q == TR_SEND && word_q == LAST_WORD);
    c_wrap: cover property (@(posedge ref_clk) disable iff (!rst_n)
        frame_start && running && auto_mode && pos_q == list_len_q);
    c_lut16: cover property (@(posedge ref_clk) disable iff (!rst_n)
        pix_in.valid && ctrl_q[CTRL_LUT_EN] && ctrl_q[CTRL_OUT16]);

endmodule

// *** design/llt_pkg.sv ***
// Purpose: shared constants and carriers of the line lookup and trailer stage
// Assumes: one acquisition clock, APB register access
// Notes:   byte offsets are word aligned
package llt_pkg;

    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_LIST_LEN = 8'h04;
    localparam logic [7:0] OFS_SET      = 8'h08;
    localparam logic [7:0] OFS_ENTRY    = 8'h0C;
    localparam logic [7:0] OFS_PAIR     = 8'h10;
    localparam logic [7:0] OFS_STATUS   = 8'h14;
    localparam logic [7:0] OFS_LUT_ADDR = 8'h18;
    localparam logic [7:0] OFS_LUT_DATA = 8'h1C;
    localparam logic [7:0] OFS_FRAME    = 8'h20;

    localparam int CTRL_LUT_EN  = 0;
    localparam int CTRL_OUT16   = 1;
    localparam int CTRL_WIDTH_L = 2;
    localparam int CTRL_TRAILER = 4;
    localparam int CTRL_AUTO    = 5;
    localparam int CTRL_RUN     = 6;
    localparam logic [6:0] CTRL_RESET = 7'h00;

    localparam logic [1:0] WIDTH_8  = 2'h0;
    localparam logic [1:0] WIDTH_10 = 2'h1;
    localparam logic [1:0] WIDTH_12 = 2'h2;

    localparam int LUT_DEPTH      = 1024;
    localparam int TRAILER_BYTES  = 64;
    localparam int TRAILER_WORDS  = TRAILER_BYTES / 2;
    localparam int RESERVED_BYTES = 25;
    localparam logic [4:0] LAST_WORD = 5'h1F;

    typedef struct packed {
        logic        valid;
        logic [11:0] data;
    } llt_pix_in_t;

    typedef struct packed {
        logic        valid;
        logic        trailer;
        logic [15:0] data;
    } llt_pix_out_t;

    typedef struct packed {
        logic [7:0]  bidir;
        logic [7:0]  outs;
        logic [7:0]  ins;
        logic [31:0] frame;
        logic [63:0] stamp;
        logic [63:0] trig;
        logic [63:0] lines;
        logic [63:0] enc;
    } llt_record_t;

endpackage

// *** testbench/llt_camera_model.sv ***
// Purpose: camera model driving frame, line and pixel levels
// Assumes: levels change by non-blocking assignment after rising edges
// Notes:   idle pixel data shows the inverse of the last value
////////////////////////////////////////////////////////////////////////////////
module llt_camera_model (
    input  wire logic            ref_clk,
    output logic                 frame_valid,
    output logic                 line_valid_strobe,
    output llt_pkg::llt_pix_in_t pix_in
);
    timeunit 1ns;
    timeprecision 1ns;
    import llt_pkg::*;

    initial begin
        frame_valid = 1'b0;
        line_valid_strobe = 1'b0;
        pix_in = '0;
    end

    task automatic frame(input logic on);
        @(posedge ref_clk);
        frame_valid <= on;
    endtask

    task automatic lv(input logic on);
        @(posedge ref_clk);
        line_valid_strobe <= on;
    endtask

    // one pixel, then the bus goes idle with the pixel data inverted
    task automatic pix(input logic [11:0] d);
        @(posedge ref_clk);
        pix_in <= '{valid: 1'b1, data: d};
        @(posedge ref_clk);
        pix_in <= '{valid: 1'b0, data: ~d};
    endtask
endmodule

// *** testbench/llt_line_stage_tb_top.sv ***
// Purpose: self-checking bench of the line lookup and trailer stage
// Assumes: zero wait APB slave, camera model drives the pixel side
// Notes:   pins, encoder and trigger pulses are driven here
////////////////////////////////////////////////////////////////////////////////
module llt_line_stage_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import llt_pkg::*;

    logic         ref_clk, rst_n, psel, penable, pwrite, pready, pslverr;
    logic [7:0]   paddr, correction_entry, ins, outs, bid;
    logic [31:0]  pwdata, prdata, coeff_wdata, wr_last, rdv;
    logic         lvs, fvs, enc_f, enc_r, trig, coeff_wr, er;
    llt_pix_in_t  pix_in;
    llt_pix_out_t pix_out;
    llt_record_t  ra, rb, rc;
    int           miscompares, checks_done, cyc, wr_cnt, t1, t2;

    llt_line_stage llt_line_stage_i (.ref_clk(ref_clk), .rst_n(rst_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .line_valid_strobe(lvs), .frame_valid(fvs),
        .pix_in(pix_in), .enc_fwd_pulse(enc_f), .enc_rev_pulse(enc_r),
        .line_trigger_sent(trig), .input_pin_levels(ins),
        .output_pin_levels(outs), .bidir_pin_levels(bid),
        .pix_out(pix_out), .correction_entry(correction_entry),
        .coeff_wr(coeff_wr), .coeff_wdata(coeff_wdata));
    llt_camera_model llt_camera_model_i (.ref_clk(ref_clk),
        .frame_valid(fvs), .line_valid_strobe(lvs), .pix_in(pix_in));

    ////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [63:0] e,
                       input logic [63:0] g);
        checks_done++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected %s expected %0h seen %0h", nm, e, g);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) miscompares++;
        rdv = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic px(input logic [11:0] d, input logic [15:0] e);
        llt_camera_model_i.pix(d);
        #1;
        chk("pixel", {2'b10, e}, pix_out);
    endtask

    // one line with mid-line pin and encoder activity, then its trailer
    task automatic line(input int words, output llt_record_t r, output int t);
        logic [511:0] w;
        int k, n;
        llt_camera_model_i.lv(1'b1);
        t = cyc;
        @(posedge ref_clk);
        enc_f <= 1'b1;
        ins <= 8'hFF;
        @(posedge ref_clk);
        enc_f <= 1'b0;
        px(12'h0A5, 16'h00A5);
        llt_camera_model_i.lv(1'b0);
        k = 0;
        n = 0;
        w = '0;
        while (k < 32 && n < 120) begin
            @(posedge ref_clk);
            n++;
            if (pix_out.valid && pix_out.trailer) begin
                w[16*k +: 16] = pix_out.data;
                k++;
            end
        end
        chk("trailer words", words, k);
        chk("reserved", 0, 64'(|w[511:312]));
        r = w[311:0];
    endtask

    task automatic fr(input logic [7:0] e);
        llt_camera_model_i.frame(1'b0);
        llt_camera_model_i.frame(1'b1);
        repeat (3) @(posedge ref_clk);
        chk("entry", e, correction_entry);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    localparam logic [35:0] MODES [8] = '{
        {8'h01, 12'h03C, 16'h00A7}, {8'h03, 12'h03C, 16'h00A7},
        {8'h05, 12'h1C4, 16'h005E}, {8'h07, 12'h3C3, 16'h02B7},
        {8'h09, 12'hABC, 16'h00AB}, {8'h0B, 12'hABC, 16'h0ABC},
        {8'h06, 12'h3C3, 16'h03C3}, {8'h02, 12'h0A5, 16'h00A5}};
    localparam logic [31:0] LUTS [3] = '{32'h03C, 32'h1C4, 32'h3C3};
    localparam logic [31:0] LUTV [3] = '{32'hA7, 32'h5E, 32'h2B7};

    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (coeff_wr === 1'b1) begin
            wr_cnt <= wr_cnt + 1;
            wr_last <= coeff_wdata;
        end
        if (cyc == 20000) begin
            miscompares++;
            tally_and_finish;
        end
    end

    initial begin
        {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
        {enc_f, enc_r, trig, miscompares, checks_done, cyc, wr_cnt} = '0;
        {ins, outs, bid} = {8'h5A, 8'hC3, 8'h81};
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, OFS_LUT_ADDR, LUTS[i]);
            apb(1'b1, OFS_LUT_DATA, LUTV[i]);
        end
        apb(1'b1, OFS_LUT_ADDR, 32'h3C3);
        apb(1'b0, OFS_LUT_DATA, 32'h0);
        chk("lut read", 32'h2B7, rdv);
        foreach (MODES[i]) begin
            apb(1'b1, OFS_CTRL, 32'(MODES[i][35:28]));
            px(MODES[i][27:16], MODES[i][15:0]);
        end
        for (int i = 0; i < 3; i++) begin
            @(posedge ref_clk);
            enc_f <= 1'b1;
            trig <= (i < 2);
            @(posedge ref_clk);
            {enc_f, trig} <= 2'b00;
        end
        enc_r <= 1'b1;
        @(posedge ref_clk);
        enc_r <= 1'b0;
        apb(1'b1, OFS_CTRL, 32'h12);
        llt_camera_model_i.frame(1'b1);
        line(32, ra, t1);
        chk("enc", 2, ra.enc);
        chk("lines", 0, ra.lines);
        chk("trig", 2, ra.trig);
        chk("frame", 1, ra.frame);
        chk("pins", 24'h81C35A, {ra.bidir, ra.outs, ra.ins});
        line(32, rb, t2);
        chk("enc2", 3, rb.enc);
        chk("lines2", 1, rb.lines);
        chk("ins2", 8'hFF, rb.ins);
        chk("stamp", t2 - t1, rb.stamp - ra.stamp);
        apb(1'b1, OFS_CTRL, 32'h02);
        line(0, rc, t2);
        apb(1'b1, OFS_LIST_LEN, 32'h2);
        apb(1'b1, OFS_SET, 32'h5);
        apb(1'b1, OFS_CTRL, 32'h60);
        fr(8'h50);
        apb(1'b1, OFS_SET, 32'hF);
        fr(8'h51);
        fr(8'h52);
        fr(8'hF0);
        fr(8'hF1);
        apb(1'b1, OFS_CTRL, 32'h20);
        apb(1'b1, OFS_PAIR, 32'h7);
        apb(1'b1, OFS_CTRL, 32'h60);
        fr(8'hF1);
        apb(1'b1, OFS_CTRL, 32'h20);
        apb(1'b1, OFS_SET, 32'h3);
        apb(1'b1, OFS_CTRL, 32'h60);
        fr(8'h30);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk("status", 32'h0000_3013, rdv);
        apb(1'b1, OFS_CTRL, 32'h20);
        apb(1'b1, OFS_CTRL, 32'h00);
        apb(1'b1, OFS_ENTRY, 32'h9C);
        apb(1'b1, OFS_CTRL, 32'h40);
        fr(8'h9C);
        apb(1'b1, OFS_LUT_DATA, 32'h123);
        repeat (2) @(posedge ref_clk);
        chk("coeff writes", 4, wr_cnt);
        chk("coeff data", 32'h123, wr_last);
        apb(1'b1, OFS_FRAME, 32'h0);
        apb(1'b0, OFS_FRAME, 32'h0);
        chk("frames", 9, rdv);
        apb(1'b0, 8'h40, 32'h0);
        chk("unmapped", 33'h100000000, {er, rdv});
        tally_and_finish;
    end
endmodule
